// *** src/dio_bank.sv ***
// Six-port digital I/O bank with command, error and interrupt path
`include "dio_defines.svh"
`timescale 1ns/1ps
module dio_bank (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [47:0] pinIn,
  output logic [47:0] pinOut,
  output logic [47:0] pinOe,
  input wire logic [5:0] extTriIn,
  output logic errLed,
  output logic irq
);
  // Control registers
  logic [5:0] dir_reg;
  logic [5:0] pol_reg;
  logic [5:0] tri_reg;
  logic [47:0] out_reg;
  logic [5:0] inSel_reg;
  logic [47:0] inData_reg;
  logic [7:0] errCode_reg;
  logic errPend_reg;
  logic errLed_reg;
  logic req_reg;
  logic reqEn_reg;
  logic [`ST_W-1:0] stat_reg;
  logic [`ST_W-1:0] mask_reg;
  logic [7:0] testCnt_reg;
  logic [2:0] outSel_reg;
  logic [31:0] rdata_reg;
  dio_pkg::ctrl_state_t state_reg;
  dio_pkg::ctrl_state_t state_next;

  logic [47:0] pinSync;
  logic [5:0] extTriSync;
  logic [47:0] inValue;

  // Pins come from outside; two flops before any use
  dio_sync #(.W(48)) uPinSync (
    .clk(clk),
    .rst_b(rst_b),
    .din(pinIn),
    .dout(pinSync)
  );
  dio_sync #(.W(6)) uTriSync (
    .clk(clk),
    .rst_b(rst_b),
    .din(extTriIn),
    .dout(extTriSync)
  );

  // One instance per port
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_PORTS; gi = gi + 1) begin : gPort
      dio_port uPort (
        .clk(clk),
        .rst_b(rst_b),
        .isOutput(dir_reg[gi]),
        .activeLow(pol_reg[gi]),
        .intTri(tri_reg[gi] | (state_reg == dio_pkg::ST_TEST)),
        .extTri(extTriSync[gi]),
        .outValue(out_reg[gi*8 +: 8]),
        .pinSync(pinSync[gi*8 +: 8]),
        .pinOut(pinOut[gi*8 +: 8]),
        .pinOe(pinOe[gi*8 +: 8]),
        .inValue(inValue[gi*8 +: 8])
      );
    end
  endgenerate

  // Write decoding
  logic wrDir, wrPol, wrTri, wrCmd, wrOut, wrStat, wrMask, wrInSel;
  logic wrOutSel, cmdOk, pollRd;
  logic [7:0] cmd;
  assign wrDir = wr && (addr == `OFF_DIR);
  assign wrPol = wr && (addr == `OFF_POL);
  assign wrTri = wr && (addr == `OFF_TRI);
  assign wrCmd = wr && (addr == `OFF_CMD);
  assign wrOut = wr && (addr == `OFF_OUT0);
  assign wrStat = wr && (addr == `OFF_STAT);
  assign wrMask = wr && (addr == `OFF_MASK);
  assign wrInSel = wr && (addr == `OFF_INSEL);
  assign wrOutSel = wr && (addr == `OFF_OUTSEL);
  assign pollRd = rd && (addr == `OFF_POLL);
  assign cmd = wdata[7:0];
  // Accepted, except query, only while no error is pending and idle
  assign cmdOk = !errPend_reg && (state_reg == dio_pkg::ST_IDLE);

  // Port configuration writes are commands too, and so are refused on error
  logic cfgOk;
  assign cfgOk = cmdOk;

  // Command classification
  logic doReset, doTest, doInput, doQuery, doBad;
  assign doReset = wrCmd && cmdOk && (cmd == `CMD_RESET);
  assign doTest = wrCmd && cmdOk && (cmd == `CMD_SELFTEST);
  assign doInput = wrCmd && cmdOk && (cmd == `CMD_INPUT);
  assign doQuery = wrCmd && (cmd == `CMD_QUERY);
  assign doBad = wrCmd && cmdOk && !doReset && !doTest && !doInput &&
                 (cmd != `CMD_QUERY);

  // Controller sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dio_pkg::ST_IDLE: begin
        if (doTest) begin
          state_next = dio_pkg::ST_TEST;
        end else if (doInput) begin
          state_next = dio_pkg::ST_SAMPLE;
        end
      end
      dio_pkg::ST_TEST: begin
        if (testCnt_reg == 8'h00) begin
          state_next = dio_pkg::ST_IDLE;
        end
      end
      dio_pkg::ST_SAMPLE: begin
        state_next = dio_pkg::ST_IDLE;
      end
      default: begin
        state_next = dio_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= dio_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Self-test holds all outputs off for a fixed time
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      testCnt_reg <= 8'h00;
    end else if (doTest) begin
      testCnt_reg <= 8'(`SELFTEST_CYC - 1);
    end else if (testCnt_reg != 8'h00) begin
      testCnt_reg <= testCnt_reg - 8'h01;
    end
  end

  // Port configuration; reset command restores defaults
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dir_reg <= `DIR_RST;
      pol_reg <= `POL_RST;
      tri_reg <= `TRI_RST;
      out_reg <= '0;
      inSel_reg <= 6'h00;
      outSel_reg <= 3'h0;
    end else if (doReset) begin
      dir_reg <= `DIR_RST;
      pol_reg <= `POL_RST;
      tri_reg <= `TRI_RST;
      out_reg <= '0;
      inSel_reg <= 6'h00;
      outSel_reg <= 3'h0;
    end else if (cfgOk) begin
      if (wrDir) dir_reg <= wdata[5:0];
      if (wrPol) pol_reg <= wdata[5:0];
      if (wrTri) tri_reg <= wdata[5:0];
      if (wrInSel) inSel_reg <= wdata[5:0];
      if (wrOutSel) outSel_reg <= wdata[2:0];
      if (wrOut && outSel_reg < 3'h6) begin
        out_reg[outSel_reg*8 +: 8] <= wdata[7:0];
      end
    end
  end

  // Sample selected ports, packed low port first
  logic [47:0] packed_next;
  always_comb begin
    int k;
    packed_next = '0;
    k = 0;
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (inSel_reg[p]) begin
        packed_next[k*8 +: 8] = inValue[p*8 +: 8];
        k = k + 1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      inData_reg <= '0;
    end else if (state_reg == dio_pkg::ST_SAMPLE) begin
      inData_reg <= packed_next;
    end
  end

  // Error path: error wins over query clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      errPend_reg <= 1'b0;
      errLed_reg <= 1'b0;
      errCode_reg <= `ERR_NONE;
      req_reg <= 1'b0;
    end else begin
      if (doBad) begin
        errPend_reg <= 1'b1;
        errCode_reg <= `ERR_SYNTAX;
        errLed_reg <= reqEn_reg;
        req_reg <= reqEn_reg | req_reg;
      end else begin
        if (doQuery) begin
          errPend_reg <= 1'b0;
          errLed_reg <= 1'b0;
        end
        if (doTest) begin
          errCode_reg <= `ERR_NONE;
        end
        if (pollRd) begin
          req_reg <= 1'b0;
        end
      end
    end
  end

  // Request enable lives in the mask register bit 0 write path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reqEn_reg <= 1'b0;
      mask_reg <= '0;
    end else if (wrMask) begin
      mask_reg <= wdata[`ST_W-1:0];
      reqEn_reg <= wdata[`ST_ERR];
    end
  end

  // Sticky events; set wins over write-one-to-clear
  logic [`ST_W-1:0] evt;
  assign evt[`ST_ERR] = doBad;
  assign evt[`ST_INDONE] = (state_reg == dio_pkg::ST_SAMPLE);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (stat_reg & ~(wrStat ? wdata[`ST_W-1:0] : '0)) | evt;
    end
  end

  // Read mux, answer one cycle after the strobe
  // Unmapped offsets fall through to zero, so no stale word leaks out
  // Address 0x1 doubles as the upper input bytes on read
  logic [31:0] rdMux;
  assign rdMux =
    (addr == `OFF_DIR) ? {26'h0, dir_reg} :
    (addr == `OFF_POL) ? {26'h0, pol_reg} :
    (addr == `OFF_TRI) ? {26'h0, tri_reg} :
    (addr == `OFF_IN0) ? inData_reg[31:0] :
    (addr == `OFF_OUT0) ? {16'h0, inData_reg[47:32]} :
    (addr == `OFF_STAT) ? {30'h0, stat_reg} :
    (addr == `OFF_MASK) ? {30'h0, mask_reg} :
    (addr == `OFF_POLL) ? {24'h0, req_reg ? `POLL_REQ : 8'h00} :
    (addr == `OFF_ERRCODE) ? {24'h0, errCode_reg} :
    (addr == `OFF_INSEL) ? {26'h0, inSel_reg} :
    (addr == `OFF_CMD) ? {30'h0, state_reg} :
    32'h0000_0000;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd) begin
      rdata_reg <= rdMux;
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign rdata = rdata_reg;
  assign errLed = errLed_reg;
  // Level interrupt: unmasked sticky bits or pending request
  assign irq = |(stat_reg & mask_reg) | req_reg;
endmodule // dio_bank

// *** include/dio_defines.svh ***
// Register offsets, field positions, reset values and timing for the port bank
`ifndef DIO_DEFINES_SVH
`define DIO_DEFINES_SVH

`define NUM_PORTS 6
`define ADDR_W 4
// Register offsets (word addresses, one word each)
`define OFF_DIR 4'h0
`define OFF_POL 4'h4
`define OFF_TRI 4'h8
`define OFF_CMD 4'hC
`define OFF_OUT0 4'h1
`define OFF_IN0 4'h2
`define OFF_STAT 4'h3
`define OFF_MASK 4'h5
`define OFF_POLL 4'h6
`define OFF_ERRCODE 4'h7
`define OFF_INSEL 4'h9
`define OFF_OUTSEL 4'hA
// Command codes written to the command register
`define CMD_RESET 8'h01
`define CMD_SELFTEST 8'h02
`define CMD_INPUT 8'h03
`define CMD_QUERY 8'h04
`define CMD_ERROR 8'h05
// Serial poll value while a request is pending
`define POLL_REQ 8'h40
// Error codes
`define ERR_NONE 8'h00
`define ERR_SYNTAX 8'h01
// Reset values
`define DIR_RST 6'h00
`define POL_RST 6'h00
`define TRI_RST 6'h3F
// Status bit positions
`define ST_ERR 0
`define ST_INDONE 1
`define ST_W 2
// Self-test duration
`define SELFTEST_NS 200
`define CLK_NS 10
`define SELFTEST_CYC ((`SELFTEST_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// *** include/dio_pkg.sv ***
// Types shared by the port bank design files
package dio_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TEST = 2'b10,
    ST_SAMPLE = 2'b01
  } ctrl_state_t;
endpackage

// *** src/dio_sync.sv ***
// Two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module dio_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // dio_sync

// *** src/dio_port.sv ***
// One byte-wide port: drive enable and polarity on both directions
`include "dio_defines.svh"
`timescale 1ns/1ps
module dio_port (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic isOutput,
  input wire logic activeLow,
  input wire logic intTri,
  input wire logic extTri,
  input wire logic [7:0] outValue,
  input wire logic [7:0] pinSync,
  output logic [7:0] pinOut,
  output logic [7:0] pinOe,
  output logic [7:0] inValue
);
  logic driveEn;
  logic [7:0] pinOutNext;

  // Either tri-state source blocks drivers
  assign driveEn = isOutput & ~intTri & ~extTri;
  // Polarity applies to outputs and inputs alike
  assign pinOutNext = activeLow ? ~outValue : outValue;
  assign inValue = activeLow ? ~pinSync : pinSync;

  // Registered pin drive
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinOut <= 8'h00;
      pinOe <= 8'h00;
    end else begin
      pinOut <= pinOutNext;
      pinOe <= {8{driveEn}};
    end
  end
endmodule // dio_port

// *** tb/dio_loopback.sv ***
// Loop-back cable model: ports 0-1, 2-3, 4-5 joined, pull-up on each line
`timescale 1ns/1ps
module dio_loopback (
  input wire logic [47:0] pinOut,
  input wire logic [47:0] pinOe,
  output logic [47:0] pinIn
);
  // Each end sees its own drive, else the far end's; nobody driving means high
  for (genvar b = 0; b < 48; b++) begin : g_bit
    assign pinIn[b] = pinOe[b] ? pinOut[b] :
      (pinOe[b ^ 8] ? pinOut[b ^ 8] : 1'b1);
  end
endmodule // dio_loopback

// *** tb/dio_bank_sva.sv ***
// Port-level assertions for the six-port bank
`include "dio_defines.svh"
`timescale 1ns/1ps
module dio_bank_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic [47:0] pinIn,
  input wire logic [47:0] pinOut,
  input wire logic [47:0] pinOe,
  input wire logic [5:0] extTriIn,
  input wire logic errLed,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Command decode shared by the command checks
  wire logic isCmd = wr && addr == `OFF_CMD;
  a_read_stands: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("rdata set outside a read answer");
  a_unmapped_zero: assert property (rd && addr == 4'hF |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_poll_value: assert property (rd && addr == `OFF_POLL |=>
    rdata == 32'h40 || rdata == 32'h0) else $error("bad poll value");
  a_reset_cmd: assert property (isCmd && wdata[7:0] == `CMD_RESET
    && !errLed |-> ##2 pinOe == 48'h0) else $error("reset left drivers on");
  a_selftest_off: assert property (isCmd && !errLed
    && wdata[7:0] == `CMD_SELFTEST |-> ##2 (pinOe == 48'h0) [*8])
    else $error("drivers on during self-test");
  a_query_led: assert property (isCmd && wdata[7:0] == `CMD_QUERY
    |-> ##[1:2] !errLed) else $error("query left error light on");
  a_irq_cause: assert property ($rose(irq) |-> $past(wr) || $past(wr, 2))
    else $error("interrupt rose with no cause");
  a_led_irq: assert property ($rose(errLed) |-> irq)
    else $error("error light without interrupt");
  // Held external tri-state must have turned the byte off by now
  for (genvar p = 0; p < 6; p++) begin : g_ext
    a_ext_tri: assert property (extTriIn[p] && $past(extTriIn[p])
      && $past(extTriIn[p], 2) && $past(extTriIn[p], 3)
      |-> pinOe[8*p +: 8] == 8'h0) else $error("external tri-state ignored");
  end
endmodule // dio_bank_sva

bind dio_bank dio_bank_sva u_dio_bank_sva (.clk(clk), .rst_b(rst_b),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .extTriIn(extTriIn),
  .errLed(errLed), .irq(irq));

// *** tb/dio_bank_tb.sv ***
// Self-checking bench for the six-port bank with loop-back cable
`include "dio_defines.svh"
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", n, e, a); end end
module dio_bank_tb;
  typedef struct {
    logic [5:0] dirCfg, polCfg, triCfg, extCfg;
    logic [7:0] outVal;
    logic [31:0] expLo;
    logic [15:0] expHi;
  } row_t;
  // Config beside the bytes an input of all ports should return
  row_t rows [9] = '{
    '{6'h15, 6'h2A, 6'h00, 6'h00, 8'h55, 32'hAA55AA55, 16'hAA55},
    '{6'h2A, 6'h15, 6'h00, 6'h00, 8'h55, 32'h55AA55AA, 16'h55AA},
    '{6'h15, 6'h00, 6'h15, 6'h00, 8'h00, 32'hFFFFFFFF, 16'hFFFF},
    '{6'h15, 6'h00, 6'h00, 6'h00, 8'h00, 32'h00000000, 16'h0000},
    '{6'h15, 6'h00, 6'h00, 6'h15, 8'h00, 32'hFFFFFFFF, 16'hFFFF},
    '{6'h15, 6'h00, 6'h00, 6'h2A, 8'h00, 32'h00000000, 16'h0000},
    '{6'h15, 6'h15, 6'h00, 6'h00, 8'h55, 32'hAA55AA55, 16'hAA55},
    '{6'h2A, 6'h2A, 6'h00, 6'h00, 8'h55, 32'h55AA55AA, 16'h55AA},
    '{6'h2A, 6'h00, 6'h2A, 6'h00, 8'h00, 32'hFFFFFFFF, 16'hFFFF}};
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, errLed, irq;
  logic [`ADDR_W-1:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [47:0] pinIn, pinOut, pinOe;
  logic [5:0] extTriIn = 6'h00;
  int checks = 0, failures = 0, cyc = 0;
  dio_bank u_dio_bank (.clk(clk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .extTriIn(extTriIn),
    .errLed(errLed), .irq(irq));
  dio_loopback u_dio_loopback (.pinOut(pinOut), .pinOe(pinOe),
    .pinIn(pinIn));
  initial begin
    forever #5 clk = ~clk;
  end
  // One gap cycle after each strobe so no signal is set twice in a step
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Ceiling well above the roughly 500 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 `CHK("pinOe", 48'h0, pinOe)
    `CHK("irq", 1'b0, irq)
    $display("reset test done");
    @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      extTriIn <= rows[i].extCfg;
      wr_reg(`OFF_CMD, {24'h0, `CMD_RESET});
      wr_reg(`OFF_DIR, {26'h0, rows[i].dirCfg});
      wr_reg(`OFF_POL, {26'h0, rows[i].polCfg});
      wr_reg(`OFF_TRI, {26'h0, rows[i].triCfg});
      wr_reg(`OFF_INSEL, 32'h3F);
      for (int p = 0; p < 6; p++) begin
        wr_reg(`OFF_OUTSEL, p);
        wr_reg(`OFF_OUT0, {24'h0, rows[i].outVal});
      end
      repeat (6) @(posedge clk);
      wr_reg(`OFF_CMD, {24'h0, `CMD_INPUT});
      @(posedge clk);
      rd_reg(`OFF_IN0, v);
      `CHK("in_lo", rows[i].expLo, v)
      rd_reg(`OFF_OUT0, v);
      `CHK("in_hi", {16'h0, rows[i].expHi}, v)
    end
    $display("row table done");
    wr_reg(`OFF_MASK, 32'h1);
    wr_reg(`OFF_CMD, {24'h0, `CMD_ERROR});
    #1 `CHK("errLed", 1'b1, errLed)
    `CHK("irq", 1'b1, irq)
    @(posedge clk);
    wr_reg(`OFF_DIR, 32'h3F);
    rd_reg(`OFF_DIR, v);
    `CHK("dir_kept", 32'h2A, v)
    rd_reg(`OFF_POLL, v);
    `CHK("poll1", {24'h0, `POLL_REQ}, v)
    rd_reg(`OFF_POLL, v);
    `CHK("poll2", 32'h0, v)
    wr_reg(`OFF_CMD, {24'h0, `CMD_QUERY});
    #1 `CHK("errLed", 1'b0, errLed)
    @(posedge clk);
    rd_reg(`OFF_ERRCODE, v);
    `CHK("errcode", {24'h0, `ERR_SYNTAX}, v)
    wr_reg(`OFF_STAT, 32'h3);
    #1 `CHK("irq", 1'b0, irq)
    @(posedge clk);
    rd_reg(4'hF, v);
    `CHK("unmapped", 32'h0, v)
    $display("error path done");
    // Drive the odd bytes so the self-test has drivers to switch off
    wr_reg(`OFF_POL, 32'h2A);
    wr_reg(`OFF_TRI, 32'h0);
    #1 `CHK("pinOut", 48'hFF00FF00FF00, pinOut)
    `CHK("pinOe_on", 48'hFF00FF00FF00, pinOe)
    @(posedge clk);
    wr_reg(`OFF_CMD, {24'h0, `CMD_SELFTEST});
    #1 `CHK("pinOe_test", 48'h0, pinOe)
    repeat (25) @(posedge clk);
    #1 `CHK("pinOe_back", 48'hFF00FF00FF00, pinOe)
    @(posedge clk);
    wr_reg(`OFF_CMD, {24'h0, `CMD_QUERY});
    rd_reg(`OFF_ERRCODE, v);
    `CHK("selftest", {24'h0, `ERR_NONE}, v)
    $display("self-test done");
    // Reset command with drivers on, then a pin reset in mid-run
    wr_reg(`OFF_CMD, {24'h0, `CMD_RESET});
    #1 `CHK("pinOe_cmd", 48'h0, pinOe)
    @(posedge clk);
    rd_reg(`OFF_POL, v);
    `CHK("pol_cmd", 32'h0, v)
    wr_reg(`OFF_CMD, {24'h0, `CMD_ERROR});
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 `CHK("errLed_rst", 1'b0, errLed)
    `CHK("irq_rst", 1'b0, irq)
    @(posedge clk);
    rd_reg(`OFF_MASK, v);
    `CHK("mask_rst", 32'h0, v)
    rd_reg(`OFF_POLL, v);
    `CHK("poll_rst", 32'h0, v)
    $display("mid-run reset done");
    close_out();
  end
endmodule // dio_bank_tb
